//--- verilog/ebsc_pkg.sv
`default_nettype none
package ebsc_pkg;
	// ==========================================================
	// Address map and configuration access
	localparam int SPACES = 5;
	localparam int ADDR_W = 25;
	localparam int SPACE_LSB = 25;
	localparam int SPACE_W = 3;
	localparam int THROUGH_BIT = 29;
	localparam int FILL_ALIGN_BITS = 4;
	localparam logic [2:0] CFG_IDX_REFCTL = 3'h5;
	localparam logic [2:0] CFG_IDX_REFCONST = 3'h6;
	localparam logic [15:0] CFG_KEY = 16'ha55a;
	localparam logic [15:0] SPACE_RST = 16'h03e0;
	localparam logic [15:0] REFCTL_RST = 16'h0000;
	localparam logic [15:0] REFCONST_RST = 16'h0000;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TP_NS = 20;
	localparam int TP_CYC = (TP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_NS = 70;
	localparam int REF_CYC = (REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRESC_W = 12;
	localparam logic [PRESC_W-1:0] CKS_MASK [8] = '{12'h000, 12'h003, 12'h00f, 12'h03f,
		12'h0ff, 12'h3ff, 12'h7ff, 12'hfff};

	// ==========================================================
	// Encodings
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [2:0] FILL_BYTES = 3'h4;
	localparam logic [1:0] FILL_UNITS_LEFT = 2'h3;

	typedef enum logic [1:0] {MT_BASIC, MT_BROM, MT_DRAM, MT_SDRAM} ebsc_mtype_t;

	typedef struct packed {
		logic [3:0] reserved;
		logic bankActive;
		logic burstWrite;
		logic [3:0] waits;
		logic [1:0] width;
		logic edo;
		logic spare;
		ebsc_mtype_t mtype;
	} ebsc_space_t;

	typedef struct packed {
		logic [6:0] reserved;
		logic writeBack;
		logic irqEnable;
		logic refreshEnable;
		logic [2:0] refCount;
		logic [2:0] clkSel;
	} ebsc_refctl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [SPACES-1:0] spaceSelectN;
		logic busCycleStartN;
		logic readWrite;
		logic rasN;
		logic casOeN;
		logic [3:0] casByteN;
		logic readPulseN;
		logic [3:0] writeEnN;
		logic [31:0] dataOut;
		logic dataOe;
	} ebsc_pins_t;

	// Size, width and refresh-count codes map to byte or cycle counts.
	function automatic logic [2:0] bytesOf(input logic [1:0] code);
		case (code)
			SZ_BYTE: bytesOf = 3'h1;
			SZ_WORD: bytesOf = 3'h2;
			default: bytesOf = 3'h4;
		endcase
	endfunction

	function automatic logic [3:0] refCountOf(input logic [2:0] code);
		case (code)
			3'h0: refCountOf = 4'h1;
			3'h1: refCountOf = 4'h2;
			3'h2: refCountOf = 4'h4;
			3'h3: refCountOf = 4'h6;
			default: refCountOf = 4'h8;
		endcase
	endfunction
endpackage
`default_nettype wire

//--- verilog/ebsc_refresh.sv
`default_nettype none
module ebsc_refresh import ebsc_pkg::*; #(
	parameter int CNT_W = 8
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] clkSel,
	input wire logic [CNT_W-1:0] constant,
	input wire logic cmpClear,
	output logic matchPulse,
	output logic cmpFlag
);
	// ==========================================================
	// Prescaler and counter
	logic [PRESC_W-1:0] presc_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	wire logic [PRESC_W-1:0] selMask = CKS_MASK[clkSel];
	wire logic tick = (clkSel != 3'h0) && ((presc_r & selMask) == selMask);
	wire logic match = tick && (count_r == constant);

	assign count_nxt = match ? '0 : (tick ? count_r + 1'b1 : count_r);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			presc_r <= '0;
			count_r <= '0;
			matchPulse <= 1'b0;
			cmpFlag <= 1'b0;
		end else begin
			presc_r <= presc_r + 1'b1;
			count_r <= count_nxt;
			matchPulse <= match;
			// A match in the clearing cycle keeps the flag set.
			cmpFlag <= match | (cmpFlag & ~cmpClear);
		end
	end
endmodule
`default_nettype wire

//--- verilog/ebsc_decode.sv
`default_nettype none
module ebsc_decode import ebsc_pkg::*; (
	input wire logic [31:0] addr,
	input wire ebsc_space_t [SPACES-1:0] spaceCfg,
	output logic [SPACE_W-1:0] space,
	output logic hit,
	output logic through,
	output ebsc_space_t cfg
);
	// ==========================================================
	// Space and area decode
	assign space = addr[SPACE_LSB +: SPACE_W];
	assign hit = space < SPACE_W'(SPACES);
	assign through = addr[THROUGH_BIT];
	assign cfg = hit ? spaceCfg[space] : '0;
endmodule
`default_nettype wire

//--- verilog/ebsc_top.sv
`default_nettype none
module ebsc_top import ebsc_pkg::*; #(
	parameter int COL_BITS = 9,
	parameter int CNT_W = 8
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic cfgWe,
	input wire logic cfgWide,
	input wire logic [2:0] cfgIdx,
	input wire logic [31:0] cfgWdata,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [31:0] reqAddr,
	input wire logic [1:0] reqSize,
	input wire logic [31:0] reqWdata,
	input wire logic reqMiss,
	input wire logic reqEvict,
	input wire logic externalWait,
	input wire logic busReleaseReq,
	input wire logic selfRefreshReq,
	input wire logic cmpClear,
	input wire logic [31:0] dataIn,
	output ebsc_pins_t memPins,
	output logic busOe,
	output logic busGrantOut,
	output logic clockEnable,
	output logic ackPulse,
	output logic ackLast,
	output logic [31:0] rdata,
	output logic busBusy,
	output logic compareMatchIrq,
	output logic cmpFlag
);
	typedef enum {ST_IDLE, ST_ADDR, ST_WAIT, ST_ROW, ST_COL, ST_PRECHARGE, ST_REF, ST_SELF,
		ST_GRANT} ebsc_state_t;

	// ==========================================================
	// Configuration registers
	ebsc_space_t [SPACES-1:0] spaceCfg_r;
	ebsc_refctl_t refCtl_r;
	logic [15:0] refConst_r;
	wire logic cfgAccept = cfgWe && cfgWide && (cfgWdata[31:16] == CFG_KEY);

	genvar gi;
	generate
		for (gi = 0; gi < SPACES; gi++) begin : g_space
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					spaceCfg_r[gi] <= SPACE_RST;
				end else if (cfgAccept && cfgIdx == 3'(gi)) begin
					spaceCfg_r[gi] <= cfgWdata[15:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			refCtl_r <= REFCTL_RST;
			refConst_r <= REFCONST_RST;
		end else if (cfgAccept) begin
			if (cfgIdx == CFG_IDX_REFCTL) refCtl_r <= cfgWdata[15:0];
			if (cfgIdx == CFG_IDX_REFCONST) refConst_r <= cfgWdata[15:0];
		end
	end

	// ==========================================================
	// Decode and refresh timer
	logic [SPACE_W-1:0] decSpace;
	logic decHit;
	logic decThrough;
	ebsc_space_t decCfg;
	logic matchPulse;

	ebsc_decode u_decode (
		.addr(reqAddr),
		.spaceCfg(spaceCfg_r),
		.space(decSpace),
		.hit(decHit),
		.through(decThrough),
		.cfg(decCfg)
	);

	ebsc_refresh #(.CNT_W(CNT_W)) u_refresh (
		.clock(clock),
		.nrst(nrst),
		.clkSel(refCtl_r.clkSel),
		.constant(refConst_r[CNT_W-1:0]),
		.cmpClear(cmpClear),
		.matchPulse(matchPulse),
		.cmpFlag(cmpFlag)
	);

	// ==========================================================
	// Byte lane helpers
	function automatic logic [1:0] laneShift(input logic [1:0] a, input logic [2:0] bb,
		input logic [2:0] busB);
		logic [2:0] off;
		off = {1'b0, a} & (busB - 3'h1) & ~(bb - 3'h1);
		laneShift = 2'(busB - off - bb);
	endfunction

	function automatic logic [1:0] beatsLeftOf(input logic [2:0] unit, input logic [2:0] busB);
		if (unit <= busB) beatsLeftOf = 2'h0;
		else if (unit == 3'h4 && busB == 3'h1) beatsLeftOf = 2'h3;
		else beatsLeftOf = 2'h1;
	endfunction

	// ==========================================================
	// Sequencer state
	ebsc_state_t state_r, state_nxt;
	ebsc_space_t cfg_r, cfg_nxt;
	logic [SPACE_W-1:0] space_r, space_nxt;
	logic write_r, write_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [2:0] unit_r, unit_nxt;
	logic [1:0] unitLeft_r, unitLeft_nxt;
	logic [1:0] beatLeft_r, beatLeft_nxt;
	logic [3:0] waitCnt_r, waitCnt_nxt;
	logic [31:0] acc_r, acc_nxt;
	logic [31:0] wsh_r, wsh_nxt;
	logic first_r, first_nxt;
	logic busy_r, busy_nxt;
	logic rowOpen_r, rowOpen_nxt;
	logic [ADDR_W-COL_BITS-1:0] openRow_r, openRow_nxt;
	logic [SPACE_W-1:0] openSpace_r, openSpace_nxt;
	logic refPend_r, refPend_nxt;
	logic [3:0] refLeft_r, refLeft_nxt;
	logic [3:0] tpCnt_r, tpCnt_nxt;
	logic [3:0] refCyc_r, refCyc_nxt;
	logic ack_nxt;
	logic last_nxt;
	logic [31:0] rdata_nxt;

	wire logic [2:0] busB = bytesOf(cfg_r.width);
	wire logic [2:0] beatB = (unit_r < busB) ? unit_r : busB;
	wire logic [1:0] rdShift = laneShift(addr_r[1:0], beatB, busB);
	wire logic [31:0] beatMask = (32'h1 << {beatB, 3'h0}) - 32'h1;
	wire logic [31:0] rdBeat = (dataIn >> {rdShift, 3'h0}) & beatMask;
	wire logic [31:0] accBeat = (acc_r << {beatB, 3'h0}) | rdBeat;
	wire logic isBasic = (cfg_r.mtype == MT_BASIC) || (cfg_r.mtype == MT_BROM);
	wire logic sdSingleWr = (cfg_r.mtype == MT_SDRAM) && !cfg_r.burstWrite && write_r;
	wire logic keepOpen = (cfg_r.mtype == MT_SDRAM) && cfg_r.bankActive;
	wire logic [2:0] reqUnit = (reqMiss && !reqWrite && !decThrough) ? FILL_BYTES : bytesOf(reqSize);
	wire logic reqFill = reqMiss && !reqWrite && !decThrough;
	wire logic absorb = !decHit || (reqWrite && !decThrough && refCtl_r.writeBack && !reqEvict);
	wire logic [ADDR_W-COL_BITS-1:0] reqRow = reqAddr[ADDR_W-1:COL_BITS];
	wire logic rowHit = rowOpen_r && openSpace_r == decSpace && openRow_r == reqRow;
	wire logic [ADDR_W-1:0] fillAddr = {reqAddr[ADDR_W-1:FILL_ALIGN_BITS], FILL_ALIGN_BITS'(0)};
	ebsc_state_t beatNext;

	always_comb begin
		if (isBasic) beatNext = ST_ADDR;
		else if (sdSingleWr) beatNext = ST_PRECHARGE;
		else beatNext = ST_COL;
	end

	always_comb begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		space_nxt = space_r;
		write_nxt = write_r;
		addr_nxt = addr_r;
		unit_nxt = unit_r;
		unitLeft_nxt = unitLeft_r;
		beatLeft_nxt = beatLeft_r;
		waitCnt_nxt = waitCnt_r;
		acc_nxt = acc_r;
		wsh_nxt = wsh_r;
		first_nxt = first_r;
		busy_nxt = busy_r;
		rowOpen_nxt = rowOpen_r;
		openRow_nxt = openRow_r;
		openSpace_nxt = openSpace_r;
		refLeft_nxt = refLeft_r;
		refCyc_nxt = refCyc_r;
		tpCnt_nxt = tpCnt_r;
		ack_nxt = 1'b0;
		last_nxt = 1'b0;
		rdata_nxt = rdata;
		refPend_nxt = refPend_r;
		case (state_r)
			ST_IDLE: begin
				if (busReleaseReq) begin
					state_nxt = rowOpen_r ? ST_PRECHARGE : ST_GRANT;
				end else if (selfRefreshReq) begin
					state_nxt = rowOpen_r ? ST_PRECHARGE : ST_SELF;
				end else if (refPend_r) begin
					if (rowOpen_r) begin
						state_nxt = ST_PRECHARGE;
					end else begin
						state_nxt = ST_REF;
						refLeft_nxt = refCountOf(refCtl_r.refCount);
						refCyc_nxt = 4'(REF_CYC - 1);
					end
				end else if (reqValid && !ackLast) begin
					if (absorb) begin
						ack_nxt = 1'b1;
						last_nxt = 1'b1;
						rdata_nxt = '0;
					end else begin
						cfg_nxt = decCfg;
						space_nxt = decSpace;
						write_nxt = reqWrite;
						addr_nxt = reqFill ? fillAddr : reqAddr[ADDR_W-1:0];
						unit_nxt = reqUnit;
						unitLeft_nxt = reqFill ? FILL_UNITS_LEFT : 2'h0;
						beatLeft_nxt = beatsLeftOf(reqUnit, bytesOf(decCfg.width));
						acc_nxt = '0;
						wsh_nxt = reqWdata << {3'h4 - reqUnit, 3'h0};
						first_nxt = 1'b1;
						busy_nxt = 1'b1;
						if (decCfg.mtype == MT_BASIC || decCfg.mtype == MT_BROM) begin
							state_nxt = ST_ADDR;
						end else if (rowHit) begin
							state_nxt = ST_COL;
						end else begin
							state_nxt = rowOpen_r ? ST_PRECHARGE : ST_ROW;
						end
					end
				end
			end
			ST_ADDR: begin
				// Later beats of a burst ROM access skip the programmed waits.
				waitCnt_nxt = (cfg_r.mtype == MT_BROM && !first_r) ? 4'h0 : cfg_r.waits;
				state_nxt = ST_WAIT;
			end
			ST_ROW: begin
				rowOpen_nxt = 1'b1;
				openRow_nxt = addr_r[ADDR_W-1:COL_BITS];
				openSpace_nxt = space_r;
				state_nxt = ST_COL;
			end
			ST_COL: begin
				waitCnt_nxt = cfg_r.waits;
				state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (waitCnt_r != 4'h0) begin
					waitCnt_nxt = waitCnt_r - 4'h1;
				end else if (!externalWait) begin
					acc_nxt = accBeat;
					wsh_nxt = wsh_r << {beatB, 3'h0};
					addr_nxt = addr_r + ADDR_W'(beatB);
					first_nxt = 1'b0;
					if (beatLeft_r != 2'h0) begin
						beatLeft_nxt = beatLeft_r - 2'h1;
						state_nxt = beatNext;
					end else begin
						ack_nxt = 1'b1;
						rdata_nxt = accBeat;
						acc_nxt = '0;
						if (unitLeft_r != 2'h0) begin
							unitLeft_nxt = unitLeft_r - 2'h1;
							beatLeft_nxt = beatsLeftOf(unit_r, busB);
							state_nxt = beatNext;
						end else begin
							last_nxt = 1'b1;
							busy_nxt = 1'b0;
							state_nxt = (isBasic || keepOpen) ? ST_IDLE : ST_PRECHARGE;
						end
					end
				end
			end
			ST_PRECHARGE: begin
				rowOpen_nxt = 1'b0;
				if (tpCnt_r != 4'h0) begin
					tpCnt_nxt = tpCnt_r - 4'h1;
				end else begin
					state_nxt = busy_r ? ST_ROW : ST_IDLE;
				end
			end
			ST_REF: begin
				if (refCyc_r != 4'h0) begin
					refCyc_nxt = refCyc_r - 4'h1;
				end else if (refLeft_r == 4'h1) begin
					refPend_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end else begin
					refLeft_nxt = refLeft_r - 4'h1;
					refCyc_nxt = 4'(REF_CYC - 1);
				end
			end
			ST_SELF: begin
				if (!selfRefreshReq) state_nxt = ST_PRECHARGE;
			end
			ST_GRANT: begin
				if (!busReleaseReq) state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (state_nxt == ST_PRECHARGE && state_r != ST_PRECHARGE) tpCnt_nxt = 4'(TP_CYC - 1);
		// A timer match in the completing cycle still leaves a refresh pending.
		if (matchPulse && refCtl_r.refreshEnable) refPend_nxt = 1'b1;
	end

	// ==========================================================
	// Pin values for the coming cycle
	ebsc_pins_t pins_nxt;
	wire logic [2:0] busBn = bytesOf(cfg_nxt.width);
	wire logic [2:0] beatBn = (unit_nxt < busBn) ? unit_nxt : busBn;
	wire logic [1:0] wrShift = laneShift(addr_nxt[1:0], beatBn, busBn);
	wire logic [3:0] laneMask = 4'((5'h1 << beatBn) - 5'h1) << wrShift;
	wire logic [31:0] wrBeat = wsh_nxt >> {3'h4 - beatBn, 3'h0};
	wire logic inCycle = state_nxt inside {ST_ADDR, ST_WAIT, ST_ROW, ST_COL};
	wire logic basicN = (cfg_nxt.mtype == MT_BASIC) || (cfg_nxt.mtype == MT_BROM);
	wire logic [ADDR_W-1:0] rowAddr = ADDR_W'(addr_nxt[ADDR_W-1:COL_BITS]);
	wire logic [ADDR_W-1:0] colAddr = ADDR_W'(addr_nxt[COL_BITS-1:0]);

	always_comb begin
		pins_nxt = '0;
		pins_nxt.addr = addr_nxt;
		pins_nxt.spaceSelectN = '1;
		pins_nxt.busCycleStartN = 1'b1;
		pins_nxt.readWrite = 1'b1;
		pins_nxt.rasN = 1'b1;
		pins_nxt.casOeN = 1'b1;
		pins_nxt.casByteN = '1;
		pins_nxt.readPulseN = 1'b1;
		pins_nxt.writeEnN = '1;
		pins_nxt.dataOut = wrBeat << {wrShift, 3'h0};
		if (inCycle) begin
			if (cfg_nxt.mtype != MT_DRAM) pins_nxt.spaceSelectN[space_nxt] = 1'b0;
			pins_nxt.readWrite = !write_nxt;
			pins_nxt.readPulseN = write_nxt || state_nxt == ST_ROW;
			pins_nxt.dataOe = write_nxt && state_nxt != ST_ROW;
			if (write_nxt && state_nxt != ST_ROW) pins_nxt.writeEnN = ~laneMask;
			if (basicN) begin
				pins_nxt.busCycleStartN = state_nxt != ST_ADDR;
			end else begin
				pins_nxt.rasN = 1'b0;
				pins_nxt.addr = (state_nxt == ST_ROW) ? rowAddr : colAddr;
				if (state_nxt != ST_ROW) pins_nxt.casByteN = ~laneMask;
				if (cfg_nxt.mtype == MT_SDRAM) begin
					pins_nxt.casOeN = state_nxt != ST_COL;
				end else if (cfg_nxt.edo) begin
					pins_nxt.casOeN = write_nxt || state_nxt == ST_ROW;
				end
			end
		end else if (state_nxt == ST_REF || state_nxt == ST_SELF) begin
			// CAS leads RAS by one cycle at the start of every auto-refresh; self-refresh drops both together.
			pins_nxt.casByteN = '0;
			pins_nxt.casOeN = 1'b0;
			pins_nxt.rasN = (state_nxt == ST_REF) && refCyc_nxt == 4'(REF_CYC - 1);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cfg_r <= '0;
			space_r <= '0;
			write_r <= 1'b0;
			addr_r <= '0;
			unit_r <= '0;
			unitLeft_r <= '0;
			beatLeft_r <= '0;
			waitCnt_r <= '0;
			acc_r <= '0;
			wsh_r <= '0;
			first_r <= 1'b0;
			busy_r <= 1'b0;
			rowOpen_r <= 1'b0;
			openRow_r <= '0;
			openSpace_r <= '0;
			refPend_r <= 1'b0;
			refLeft_r <= '0;
			refCyc_r <= '0;
			tpCnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			space_r <= space_nxt;
			write_r <= write_nxt;
			addr_r <= addr_nxt;
			unit_r <= unit_nxt;
			unitLeft_r <= unitLeft_nxt;
			beatLeft_r <= beatLeft_nxt;
			waitCnt_r <= waitCnt_nxt;
			acc_r <= acc_nxt;
			wsh_r <= wsh_nxt;
			first_r <= first_nxt;
			busy_r <= busy_nxt;
			rowOpen_r <= rowOpen_nxt;
			openRow_r <= openRow_nxt;
			openSpace_r <= openSpace_nxt;
			refPend_r <= refPend_nxt;
			refLeft_r <= refLeft_nxt;
			refCyc_r <= refCyc_nxt;
			tpCnt_r <= tpCnt_nxt;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			memPins <= '{addr: '0, spaceSelectN: '1, busCycleStartN: 1'b1, readWrite: 1'b1,
				rasN: 1'b1, casOeN: 1'b1, casByteN: '1, readPulseN: 1'b1, writeEnN: '1,
				dataOut: '0, dataOe: 1'b0};
			busOe <= 1'b1;
			busGrantOut <= 1'b0;
			clockEnable <= 1'b1;
			ackPulse <= 1'b0;
			ackLast <= 1'b0;
			rdata <= '0;
			busBusy <= 1'b0;
			compareMatchIrq <= 1'b0;
		end else begin
			memPins <= pins_nxt;
			busOe <= state_nxt != ST_GRANT;
			busGrantOut <= state_nxt == ST_GRANT;
			clockEnable <= state_nxt != ST_SELF;
			ackPulse <= ack_nxt;
			ackLast <= last_nxt;
			rdata <= rdata_nxt;
			busBusy <= state_nxt != ST_IDLE;
			compareMatchIrq <= cmpFlag && refCtl_r.irqEnable;
		end
	end

endmodule
`default_nettype wire

//--- verification/ebsc_chk.sv
`default_nettype none
module ebsc_chk import ebsc_pkg::*; #(
	parameter int COL_BITS = 9,
	parameter int CNT_W = 8
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic busReleaseReq,
	input wire logic selfRefreshReq,
	input wire ebsc_pins_t memPins,
	input wire logic busOe,
	input wire logic busGrantOut,
	input wire logic clockEnable,
	input wire logic ackPulse,
	input wire logic ackLast,
	input wire logic compareMatchIrq,
	input wire logic cmpFlag
);
	// ==========================================================
	// Pin and handshake relations
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	start_one_cycle_a: assert property ($fell(memPins.busCycleStartN) |=>
		memPins.busCycleStartN) else $error("start strobe held too long");
	one_select_a: assert property ($onehot0(~memPins.spaceSelectN))
		else $error("two spaces selected at once");
	grant_float_a: assert property (busGrantOut |-> !busOe)
		else $error("pins driven while granted");
	grant_cause_a: assert property (busGrantOut |-> $past(busReleaseReq))
		else $error("grant without release request");
	read_no_drive_a: assert property (!memPins.readPulseN |-> !memPins.dataOe)
		else $error("data driven during read pulse");
	read_dir_a: assert property (!memPins.readPulseN |-> memPins.readWrite)
		else $error("read pulse in a write cycle");
	last_unit_a: assert property (ackLast |-> ackPulse)
		else $error("access end without unit done");
	irq_flag_a: assert property (compareMatchIrq |-> $past(cmpFlag))
		else $error("interrupt without compare flag");
	cke_self_a: assert property ($fell(clockEnable) |-> $past(selfRefreshReq))
		else $error("clock enable dropped without request");
endmodule
`default_nettype wire

//--- verification/ebsc_mem_model.sv
`default_nettype none
module ebsc_mem_model import ebsc_pkg::*; (
	input wire logic clock,
	input wire ebsc_pins_t memPins,
	input wire logic busOe,
	output logic [31:0] dataIn
);
	// ==========================================================
	// Read data
	// Outside a read pulse the bus toggles every cycle, so a late sample cannot match.
	logic [31:0] lastData = 32'h0;
	assign dataIn = (busOe && !memPins.readPulseN) ? {4{memPins.addr[7:0]}} : ~lastData;
	always @(posedge clock) begin
		lastData <= dataIn;
	end
endmodule
`default_nettype wire

//--- verification/ebsc_tb.sv
`default_nettype none
module ebsc_tb import ebsc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Stimulus and instances
	logic clock = 1'b0, nrst = 1'b0, cfgWe = 1'b0, cfgWide = 1'b0, reqValid = 1'b0;
	logic reqMiss = 1'b0, busReleaseReq = 1'b0, selfRefreshReq = 1'b0, cmpClear = 1'b0;
	logic reqWrite = 1'b0;
	logic [31:0] reqWdata = 32'h0;
	logic [2:0] cfgIdx = 3'h0;
	logic [31:0] cfgWdata = 32'h0, reqAddr = 32'h0, rdata, rd;
	logic [1:0] reqSize = SZ_LONG;
	logic [31:0] dataIn;
	ebsc_pins_t memPins, seen;
	logic busOe, busGrantOut, clockEnable, ackPulse, ackLast, busBusy, compareMatchIrq, cmpFlag;
	int errors = 0, n_checks = 0, lat, nack;
	always #5 clock = ~clock;
	ebsc_top i_ebsc_top (.clock(clock), .nrst(nrst), .cfgWe(cfgWe), .cfgWide(cfgWide),
		.cfgIdx(cfgIdx), .cfgWdata(cfgWdata), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqSize(reqSize), .reqWdata(reqWdata), .reqMiss(reqMiss),
		.reqEvict(1'b0), .externalWait(1'b0), .busReleaseReq(busReleaseReq),
		.selfRefreshReq(selfRefreshReq), .cmpClear(cmpClear), .dataIn(dataIn),
		.memPins(memPins), .busOe(busOe), .busGrantOut(busGrantOut),
		.clockEnable(clockEnable), .ackPulse(ackPulse), .ackLast(ackLast), .rdata(rdata),
		.busBusy(busBusy), .compareMatchIrq(compareMatchIrq), .cmpFlag(cmpFlag));
	ebsc_mem_model i_ebsc_mem_model (.clock(clock), .memPins(memPins), .busOe(busOe),
		.dataIn(dataIn));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic [2:0] idx, input logic [15:0] key, input logic [15:0] v);
		@(posedge clock);
		cfgWe <= 1'b1;
		cfgWide <= 1'b1;
		cfgIdx <= idx;
		cfgWdata <= {key, v};
		@(posedge clock);
		cfgWe <= 1'b0;
	endtask
	// The request is held until the end of the access and dropped at the next edge.
	task automatic access(input logic [31:0] a, input logic miss);
		lat = 0;
		nack = 0;
		@(posedge clock);
		reqValid <= 1'b1;
		reqAddr <= a;
		reqMiss <= miss;
		do begin
			@(negedge clock);
			lat++;
			if (memPins.spaceSelectN !== 5'h1f || memPins.rasN === 1'b0) seen = memPins;
			if (ackPulse === 1'b1) begin
				nack++;
				rd = rdata;
			end
		end while (ackLast !== 1'b1 && lat < 300);
		@(posedge clock);
		reqValid <= 1'b0;
		reqMiss <= 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_waits();
		int a;
		chk({busOe, busGrantOut, clockEnable, ackPulse, memPins.dataOe}, 5'h14);
		chk(memPins.spaceSelectN, 5'h1f);
		access(32'h0000_0010, 1'b0);
		a = lat;
		chk(rd, 32'h1010_1010);
		cfg(3'h0, CFG_KEY, 16'h0020);
		access(32'h0000_0010, 1'b0);
		chk(32'(a - lat), 32'h0f);
		a = lat;
		cfg(3'h0, CFG_KEY, 16'h00a0);
		access(32'h0000_0010, 1'b0);
		chk(32'(lat - a), 32'h02);
		a = lat;
		cfg(3'h0, 16'h5aa5, 16'h0160);
		access(32'h0000_0010, 1'b0);
		chk(32'(lat), 32'(a));
	endtask
	task automatic t_width_fill();
		cfg(3'h1, CFG_KEY, 16'h0000);
		access(32'h0200_0020, 1'b0);
		chk(rd, 32'h2021_2223);
		chk(32'(nack), 32'h1);
		access(32'h0000_0034, 1'b1);
		chk(32'(nack), 32'h4);
		access(32'h2000_0034, 1'b1);
		chk(32'(nack), 32'h1);
		chk(rd, 32'h3434_3434);
		access(32'h0a00_0000, 1'b0);
		chk(rd, 32'h0);
	endtask
	task automatic t_grant_self();
		@(posedge clock);
		busReleaseReq <= 1'b1;
		repeat (4) @(negedge clock);
		chk({busGrantOut, busOe}, 2'h2);
		@(posedge clock);
		busReleaseReq <= 1'b0;
		repeat (4) @(negedge clock);
		chk({busGrantOut, busOe}, 2'h1);
		@(posedge clock);
		selfRefreshReq <= 1'b1;
		for (int i = 0; i < 300 && clockEnable !== 1'b0; i++) @(negedge clock);
		chk(clockEnable, 1'b0);
		@(posedge clock);
		selfRefreshReq <= 1'b0;
		for (int i = 0; i < 300 && clockEnable !== 1'b1; i++) @(negedge clock);
		chk(clockEnable, 1'b1);
	endtask
	task automatic t_irq();
		cfg(CFG_IDX_REFCONST, CFG_KEY, 16'h0004);
		cfg(CFG_IDX_REFCTL, CFG_KEY, 16'h0081);
		for (int i = 0; i < 300 && compareMatchIrq !== 1'b1; i++) @(negedge clock);
		chk({compareMatchIrq, cmpFlag}, 2'h3);
		cfg(CFG_IDX_REFCTL, CFG_KEY, 16'h0000);
		@(posedge clock);
		cmpClear <= 1'b1;
		@(posedge clock);
		cmpClear <= 1'b0;
		@(negedge clock);
		chk({compareMatchIrq, cmpFlag}, 2'h0);
	endtask
	task automatic t_refresh();
		int n = 0;
		cfg(CFG_IDX_REFCONST, CFG_KEY, 16'h0010);
		cfg(CFG_IDX_REFCTL, CFG_KEY, 16'h0049);
		for (int i = 0; i < 300 && memPins.casByteN !== 4'h0; i++) @(negedge clock);
		while (memPins.casByteN === 4'h0 && n < 300) begin
			n++;
			@(negedge clock);
		end
		chk(32'(n), 32'(2 * REF_CYC));
		cfg(CFG_IDX_REFCTL, CFG_KEY, 16'h0000);
	endtask
	task automatic t_dram();
		cfg(3'h3, CFG_KEY, 16'h0022);
		access(32'h0600_0234, 1'b0);
		chk(rd, 32'h3434_3434);
		chk(seen.addr, 25'h034);
		chk(seen.spaceSelectN, 5'h1f);
		chk({seen.rasN, seen.casOeN, seen.readPulseN}, 3'h2);
		chk(busBusy, 1'b1);
	endtask
	task automatic t_write();
		reqWrite <= 1'b1;
		reqSize <= SZ_BYTE;
		reqWdata <= 32'h0000_00a5;
		access(32'h0000_0011, 1'b0);
		chk(seen.writeEnN, 4'hb);
		chk(seen.dataOut, 32'h00a5_0000);
		chk({seen.readWrite, seen.dataOe}, 2'h1);
		cfg(CFG_IDX_REFCTL, CFG_KEY, 16'h0100);
		access(32'h0000_0010, 1'b0);
		chk(32'(lat), 32'h2);
		access(32'h2000_0010, 1'b0);
		chk(32'(lat), 32'h6);
		reqWrite <= 1'b0;
		reqSize <= SZ_LONG;
	endtask
	task automatic finish_test();
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		t_waits();
		t_width_fill();
		t_grant_self();
		t_irq();
		t_refresh();
		t_dram();
		t_write();
		finish_test();
	end
	initial begin
		#100000;
		errors++;
		finish_test();
	end
endmodule
bind ebsc_top ebsc_chk #(.COL_BITS(COL_BITS), .CNT_W(CNT_W)) i_ebsc_chk (.clock(clock),
	.nrst(nrst), .busReleaseReq(busReleaseReq), .selfRefreshReq(selfRefreshReq),
	.memPins(memPins), .busOe(busOe), .busGrantOut(busGrantOut), .clockEnable(clockEnable),
	.ackPulse(ackPulse), .ackLast(ackLast), .compareMatchIrq(compareMatchIrq),
	.cmpFlag(cmpFlag));
`default_nettype wire
